// ---- logic/adc_readout_pkg.sv ----
`default_nettype none
package adc_readout_pkg;
  // Frame geometry of one serial result word
  localparam int RESULT_W = 12;
  localparam int LEAD_ZEROS = 2;
  localparam int WORD_BITS = 16;
  localparam int CNT_W = 6;
  // Falling-edge counts that mark frame events
  localparam logic [5:0] CONV_FALLS = 6'h0d;
  localparam logic [5:0] MIN_FALLS = 6'h0e;
  localparam logic [5:0] DUAL_FALLS = 6'h20;
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 2;
  // Values after reset
  localparam logic [5:0] CNT_RESET = 6'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  // Frame states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_TRACK = 4'b0100,
    ST_DONE = 4'b1000
  } frame_state_t;
endpackage : adc_readout_pkg
`default_nettype wire

// ---- logic/pin_edge_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser with edge detection on the settled level
module pin_edge_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] idle_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] last_ff;

  // Each stage takes idle levels under reset
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_pin
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta_ff[g] <= 1'b0;
        sync_ff[g] <= 1'b0;
        last_ff[g] <= 1'b0;
      end else begin
        meta_ff[g] <= pin_i[g] ^ idle_i[g];
        sync_ff[g] <= meta_ff[g];
        last_ff[g] <= sync_ff[g];
      end
    end
    assign level_o[g] = sync_ff[g] ^ idle_i[g];
    assign rise_o[g] = (sync_ff[g] ^ idle_i[g]) & ~(last_ff[g] ^ idle_i[g]);
    assign fall_o[g] = ~(sync_ff[g] ^ idle_i[g]) & (last_ff[g] ^ idle_i[g]);
  end
endmodule : pin_edge_sync
`default_nettype wire

// ---- logic/dual_adc_serial_readout.sv ----
// Behaviour
// - Select falling: hold, sample, drive, start conversion
// - Conversion and one result need fourteen clocks
// - Track again on rising after thirteenth falling
// - Sixteen-clock frame ends with two zeros
// - Select rising ends conversion, outputs float
// - Extra clocks bring channel B onto A
// - Extra clocks bring channel A onto B
// - Dual frame floats at falling 32 or select
// - Select gives zero, first falling second zero
// - Twelve bits MSB first, last at 13th
// - Rising edge before first falling is ignored
// - Falling edge coincident with select not counted
`timescale 1ns/10ps
`default_nettype none
module dual_adc_serial_readout #(
  parameter int RES_W = adc_readout_pkg::RESULT_W
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic chip_select_b_i,
  input wire logic converter_serial_clock_i,
  input wire logic [RES_W-1:0] conv_result_a_i,
  input wire logic [RES_W-1:0] conv_result_b_i,
  output logic track_hold_o,
  output logic sample_o,
  output logic conv_done_o,
  output logic data_a_o,
  output logic data_a_oe_o,
  output logic data_b_o,
  output logic data_b_oe_o
);
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  adc_readout_pkg::frame_state_t state_ff;
  adc_readout_pkg::frame_state_t nxt_state;
  logic [adc_readout_pkg::CNT_W-1:0] cnt_ff;
  logic [adc_readout_pkg::CNT_W-1:0] nxt_cnt;
  logic [RES_W-1:0] res_a_ff;
  logic [RES_W-1:0] res_b_ff;
  logic [RES_W-1:0] nxt_res_a;
  logic [RES_W-1:0] nxt_res_b;
  logic hold_ff;
  logic nxt_hold;
  logic oe_ff;
  logic nxt_oe;
  logic bit_a_ff;
  logic bit_b_ff;
  logic nxt_bit_a;
  logic nxt_bit_b;
  logic sample_ff;
  logic nxt_sample;
  logic done_ff;
  logic nxt_done;

  // Bit on a line at a given frame position; second word is the other channel
  function automatic logic line_bit(input logic [adc_readout_pkg::CNT_W-1:0] pos,
                                    input logic [RES_W-1:0] own,
                                    input logic [RES_W-1:0] other);
    logic [3:0] q;
    logic [RES_W-1:0] word;
    q = pos[3:0];
    word = (pos < 6'(adc_readout_pkg::WORD_BITS)) ? own : other;
    if (q < 4'(adc_readout_pkg::LEAD_ZEROS) || q > 4'(RES_W + 1)) begin
      line_bit = 1'b0;
    end else begin
      line_bit = word[4'(RES_W + 1) - q];
    end
  endfunction : line_bit

  // Select (idle high) and serial clock (idle low) brought into clock_i
  pin_edge_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .pin_i({converter_serial_clock_i, chip_select_b_i}),
    .idle_i(2'b01),
    .level_o(),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign cs_fall = pin_fall[0];
  assign cs_rise = pin_rise[0];
  assign sclk_fall = pin_fall[1];
  assign sclk_rise = pin_rise[1];

  // Frame sequencing, counting and shift data
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_res_a = res_a_ff;
    nxt_res_b = res_b_ff;
    nxt_hold = hold_ff;
    nxt_oe = oe_ff;
    nxt_bit_a = bit_a_ff;
    nxt_bit_b = bit_b_ff;
    nxt_sample = 1'b0;
    nxt_done = 1'b0;
    if (cs_rise) begin
      nxt_state = adc_readout_pkg::ST_IDLE;
      nxt_hold = 1'b0;
      nxt_oe = 1'b0;
      nxt_bit_a = 1'b0;
      nxt_bit_b = 1'b0;
    end else if (cs_fall) begin
      // Coincident clock falling is dropped here
      nxt_state = adc_readout_pkg::ST_HOLD;
      nxt_cnt = adc_readout_pkg::CNT_RESET;
      nxt_res_a = conv_result_a_i;
      nxt_res_b = conv_result_b_i;
      nxt_hold = 1'b1;
      nxt_oe = 1'b1;
      nxt_sample = 1'b1;
      nxt_bit_a = 1'b0;
      nxt_bit_b = 1'b0;
    end else begin
      unique case (state_ff)
        adc_readout_pkg::ST_IDLE, adc_readout_pkg::ST_DONE: begin
          nxt_oe = 1'b0;
        end
        adc_readout_pkg::ST_HOLD, adc_readout_pkg::ST_TRACK: begin
          if (sclk_fall) begin
            nxt_cnt = cnt_ff + 6'h01;
            nxt_bit_a = line_bit(nxt_cnt, res_a_ff, res_b_ff);
            nxt_bit_b = line_bit(nxt_cnt, res_b_ff, res_a_ff);
            if (nxt_cnt == adc_readout_pkg::MIN_FALLS) begin
              nxt_done = 1'b1;
            end
            if (nxt_cnt == adc_readout_pkg::DUAL_FALLS) begin
              nxt_state = adc_readout_pkg::ST_DONE;
              nxt_oe = 1'b0;
              nxt_bit_a = 1'b0;
              nxt_bit_b = 1'b0;
            end
          end else if (sclk_rise && hold_ff && cnt_ff >= adc_readout_pkg::CONV_FALLS) begin
            nxt_hold = 1'b0;
            nxt_state = adc_readout_pkg::ST_TRACK;
          end
        end
        default: begin
          nxt_state = adc_readout_pkg::ST_IDLE;
          nxt_hold = 1'b0;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // Frame registers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= adc_readout_pkg::ST_IDLE;
      cnt_ff <= adc_readout_pkg::CNT_RESET;
      res_a_ff <= adc_readout_pkg::RESULT_RESET;
      res_b_ff <= adc_readout_pkg::RESULT_RESET;
      hold_ff <= 1'b0;
      oe_ff <= 1'b0;
      bit_a_ff <= 1'b0;
      bit_b_ff <= 1'b0;
      sample_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      res_a_ff <= nxt_res_a;
      res_b_ff <= nxt_res_b;
      hold_ff <= nxt_hold;
      oe_ff <= nxt_oe;
      bit_a_ff <= nxt_bit_a;
      bit_b_ff <= nxt_bit_b;
      sample_ff <= nxt_sample;
      done_ff <= nxt_done;
    end
  end

  // Outputs straight from flip-flops
  assign track_hold_o = hold_ff;
  assign sample_o = sample_ff;
  assign conv_done_o = done_ff;
  assign data_a_o = bit_a_ff;
  assign data_b_o = bit_b_ff;
  assign data_a_oe_o = oe_ff;
  assign data_b_oe_o = oe_ff;

  // Frame start and outputs released
  sequence seq_frame_start;
    cs_fall && !cs_rise;
  endsequence
  sequence seq_floating;
    !data_a_oe_o && !data_b_oe_o;
  endsequence

  AST_HOLD_ON_SELECT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    seq_frame_start |=> track_hold_o && sample_o && data_a_oe_o && data_b_oe_o)
    else $error("select falling did not hold and drive");

  AST_LEAD_ZERO: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    seq_frame_start |=> !data_a_o && !data_b_o)
    else $error("first leading zero missing");

  AST_DONE_AT_14: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sclk_fall && !cs_rise && !cs_fall && data_a_oe_o && cnt_ff == 6'h0d) |=> conv_done_o)
    else $error("conversion done not flagged at fourteenth falling");

  AST_TRACK_AFTER_13: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (track_hold_o && sclk_rise && !cs_rise && !cs_fall && cnt_ff >= 6'h0d) |=> !track_hold_o)
    else $error("track not resumed after thirteenth falling");

  AST_NO_EARLY_TRACK: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (track_hold_o && !cs_rise && cnt_ff < 6'h0d) |=> track_hold_o)
    else $error("track resumed too early");

  AST_TRAILING_ZEROS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sclk_fall && !cs_rise && !cs_fall && data_a_oe_o && cnt_ff == 6'h0d)
      |=> (!data_a_o && !data_b_o) ##1 (!data_a_o && !data_b_o) [*8])
    else $error("trailing zero missing after LSB");

  AST_SELECT_RISE_FLOATS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cs_rise |=> seq_floating and !track_hold_o)
    else $error("select rising did not float outputs");

  AST_B_ON_A: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sclk_fall && !cs_rise && !cs_fall && data_a_oe_o && cnt_ff == 6'h11)
      |=> data_a_o == res_b_ff[11])
    else $error("channel B MSB not on line A");

  AST_A_ON_B: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sclk_fall && !cs_rise && !cs_fall && data_b_oe_o && cnt_ff == 6'h11)
      |=> data_b_o == res_a_ff[11])
    else $error("channel A MSB not on line B");

  AST_FLOAT_AT_32: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sclk_fall && !cs_rise && !cs_fall && data_a_oe_o && cnt_ff == 6'h1f)
      |=> seq_floating ##1 (seq_floating or cs_fall))
    else $error("dual frame did not float at falling 32");

  AST_MSB_FIRST: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sclk_fall && !cs_rise && !cs_fall && data_a_oe_o && cnt_ff == 6'h01)
      |=> data_a_o == res_a_ff[11] && data_b_o == res_b_ff[11])
    else $error("result not MSB first");

  AST_RISE_NOT_COUNTED: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sclk_rise && !cs_fall && !cs_rise) |=> $stable(cnt_ff))
    else $error("rising edge changed the count");

  AST_COINCIDENT_FALL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (cs_fall && sclk_fall) |=> cnt_ff == 6'h00)
    else $error("coincident falling edge was counted");
endmodule : dual_adc_serial_readout
`default_nettype wire

// ---- dv/adc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host serial port: drives select and serial clock, captures both data lines
module adc_host_model (
  input wire logic clock_i,
  input wire logic track_hold_i,
  input wire logic sample_i,
  input wire logic conv_done_i,
  input wire logic data_a_i,
  input wire logic data_a_oe_i,
  input wire logic data_b_i,
  input wire logic data_b_oe_i,
  output logic chip_select_b_o,
  output logic converter_serial_clock_o
);
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic [31:0] hold_seen;
  int n_sample;
  int n_done;
  int oe_miss;
  // Idle: deselected, serial clock parked low
  initial begin
    chip_select_b_o = 1'b1;
    converter_serial_clock_o = 1'b0;
  end
  // Pulse counters for the current frame
  always @(posedge clock_i) begin
    if (sample_i) n_sample++;
    if (conv_done_i) n_done++;
  end
  // One frame of n falls, 8 system cycles per half period
  task automatic run_frame(input int n, input logic start_high, input logic stay_low);
    cap_a = '0;
    cap_b = '0;
    hold_seen = '0;
    n_sample = 0;
    n_done = 0;
    oe_miss = 0;
    @(negedge clock_i);
    if (start_high) begin
      converter_serial_clock_o = 1'b1;
      repeat (8) @(negedge clock_i);
    end
    chip_select_b_o = 1'b0;
    converter_serial_clock_o = 1'b0; // Falls with select when parked high
    repeat (8) @(negedge clock_i);
    for (int k = 0; k < n; k++) begin
      converter_serial_clock_o = 1'b1;
      repeat (8) @(negedge clock_i);
      // Capture just ahead of the falling edge
      oe_miss += int'(data_a_oe_i !== 1'b1) + int'(data_b_oe_i !== 1'b1);
      cap_a = {cap_a[30:0], data_a_i};
      cap_b = {cap_b[30:0], data_b_i};
      hold_seen = {hold_seen[30:0], track_hold_i};
      converter_serial_clock_o = 1'b0;
      repeat (8) @(negedge clock_i);
    end
    if (!stay_low) begin
      chip_select_b_o = 1'b1;
      repeat (8) @(negedge clock_i);
    end
  endtask : run_frame
  // Deselect after a frame left open
  task automatic release_select();
    chip_select_b_o = 1'b1;
    repeat (8) @(negedge clock_i);
  endtask : release_select
endmodule : adc_host_model
`default_nettype wire

// ---- dv/dual_adc_serial_readout_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module dual_adc_serial_readout_tb_top;
  localparam logic [11:0] RES_A = 12'ha5c;
  localparam logic [11:0] RES_B = 12'h3b1;
  logic clock_i;
  logic rst_b_i;
  logic [11:0] res_a;
  logic [11:0] res_b;
  wire logic cs_b;
  wire logic sclk;
  wire logic th;
  wire logic smp;
  wire logic done;
  wire logic da;
  wire logic da_oe;
  wire logic db;
  wire logic db_oe;
  int num_errors;
  int n_tests;
  dual_adc_serial_readout dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .chip_select_b_i(cs_b), .converter_serial_clock_i(sclk), .conv_result_a_i(res_a),
    .conv_result_b_i(res_b), .track_hold_o(th), .sample_o(smp), .conv_done_o(done),
    .data_a_o(da), .data_a_oe_o(da_oe), .data_b_o(db), .data_b_oe_o(db_oe));
  adc_host_model host (.clock_i(clock_i), .track_hold_i(th), .sample_i(smp),
    .conv_done_i(done), .data_a_i(da), .data_a_oe_i(da_oe), .data_b_i(db),
    .data_b_oe_i(db_oe), .chip_select_b_o(cs_b), .converter_serial_clock_o(sclk));
  // 200 MHz system clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check
  // Both lines idle and back in track
  task automatic check_float();
    check({29'h0, da_oe, db_oe, th}, 32'h0, "lines not floated");
  endtask : check_float
  // Sixteen-clock frame, serial clock parked low or high
  task automatic t_single(input logic start_high);
    host.run_frame(16, start_high, 1'b0);
    check(host.cap_a[15:0], {2'b00, RES_A, 2'b00}, "word A");
    check(host.cap_b[15:0], {2'b00, RES_B, 2'b00}, "word B");
    check(host.hold_seen[15:0], 16'hfff8, "hold window");
    check(host.n_sample, 1, "sample pulses");
    check(host.n_done, 1, "done pulses");
    check(host.oe_miss, 0, "drive gaps");
    check_float();
    $display("test single park=%0d finished", start_high);
  endtask : t_single
  // Shortest legal frame
  task automatic t_min14();
    host.run_frame(14, 1'b0, 1'b0);
    check(host.cap_a[13:0], {2'b00, RES_A}, "short word A");
    check(host.hold_seen[13:0], 14'h3ffe, "short hold");
    check(host.n_done, 1, "short done");
    check_float();
    $display("test min14 finished");
  endtask : t_min14
  // Both results on each line, select left low past the end
  task automatic t_dual();
    host.run_frame(32, 1'b0, 1'b1);
    check(host.cap_a, {2'b00, RES_A, 4'h0, RES_B, 2'b00}, "dual A");
    check(host.cap_b, {2'b00, RES_B, 4'h0, RES_A, 2'b00}, "dual B");
    check(host.hold_seen, 32'hfff80000, "dual hold");
    check(host.n_done, 1, "dual done");
    check(host.oe_miss, 0, "dual drive gaps");
    check({30'h0, da_oe, db_oe}, 32'h0, "float at 32nd");
    host.release_select();
    $display("test dual finished");
  endtask : t_dual
  // Select raised after eight falls
  task automatic t_abort();
    host.run_frame(8, 1'b0, 1'b0);
    check(host.cap_a[7:0], {2'b00, RES_A[11:6]}, "partial word");
    check(host.n_done, 0, "no done");
    check_float();
    $display("test abort finished");
  endtask : t_abort
  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // Hang guard, far above the fewer than two thousand cycles needed
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    num_errors = 0;
    n_tests = 0;
    rst_b_i = 1'b0;
    res_a = RES_A;
    res_b = RES_B;
    repeat (10) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clock_i);
    t_single(1'b0);
    t_min14();
    t_abort();
    t_single(1'b1);
    t_dual();
    t_single(1'b0);
    summarize();
  end
endmodule : dual_adc_serial_readout_tb_top
`default_nettype wire
